// file: vst_pkg.sv
// Switch table package.
// Assumes a single core clock domain and one register request at a time.
package vst_pkg;

    // ------------------------------------------------------------
    // Register map
    // ------------------------------------------------------------
    localparam int unsigned ADDR_W = 12;
    localparam logic [11:0] OFS_MGMT_PORT_CONTROL = 12'h354;
    localparam logic [11:0] OFS_SWITCH_ENABLE_BITS = 12'h358;
    localparam logic [11:0] OFS_SWITCH_UPSTREAM_SELECT = 12'h360;
    localparam logic [11:0] OFS_SWITCH_PORT_MEMBERSHIP = 12'h380;
    localparam logic [11:0] OFS_CONFIGURATION_RELEASE = 12'h3ac;
    localparam logic [11:0] OFS_TABLE_STRIDE = 12'h004;
    // PCI-defined header space lies below
    localparam logic [11:0] OFS_DEVICE_SPECIFIC_BASE = 12'h100;

    localparam int unsigned NUM_SWITCHES = 4;

    // ------------------------------------------------------------
    // Field layout and writable masks
    // ------------------------------------------------------------
    localparam logic [31:0] MPC_WMASK = 32'h0000_3777;
    localparam logic [31:0] ENABLE_WMASK = 32'h0000_000f;
    localparam logic [31:0] UPSTREAM_WMASK = 32'h0000_0017;
    localparam logic [31:0] VECTOR_WMASK = 32'h00ff_000f;
    localparam logic [31:0] RELEASE_WMASK = 32'h0000_0001;
    localparam logic [4:0] PORT_FIELD_MASK = 5'h17;
    localparam int unsigned MPC_ACTIVE_LSB = 0;
    localparam int unsigned MPC_ACTIVE_EN_BIT = 5;
    localparam int unsigned MPC_RELOAD_SCOPE_BIT = 6;
    localparam int unsigned MPC_REDUNDANT_LSB = 8;
    localparam int unsigned MPC_REDUNDANT_EN_BIT = 13;
    localparam int unsigned RELEASE_BIT = 0;

    // ------------------------------------------------------------
    // Reset values
    // ------------------------------------------------------------
    localparam logic [31:0] MPC_RESET = 32'h0000_0000;
    localparam logic [31:0] ENABLE_RESET = 32'h0000_0000;
    localparam logic [31:0] UPSTREAM_RESET = 32'h0000_0000;
    localparam logic [31:0] VECTOR_RESET = 32'h0000_0000;
    localparam logic [31:0] VECTOR_ALL_PORTS = 32'h00ff_000f;

    // ------------------------------------------------------------
    // Requesting agents and switch-count strap codes
    // ------------------------------------------------------------
    localparam logic [1:0] SRC_EEPROM = 2'h0;
    localparam logic [1:0] SRC_I2C = 2'h1;
    localparam logic [1:0] SRC_PORT = 2'h2;
    localparam logic [1:0] COUNT_BASE = 2'h0;
    localparam logic [1:0] COUNT_ONE = 2'h1;
    localparam logic [1:0] COUNT_TWO = 2'h2;
    localparam logic [3:0] ENABLE_ONE = 4'h1;
    localparam logic [3:0] ENABLE_TWO = 4'h3;
    localparam logic [3:0] ENABLE_FOUR = 4'hf;

    typedef enum logic [1:0] {
        VST_STRAP_WAIT,
        VST_STRAP_TAKE,
        VST_RUN
    } vst_boot_t;

endpackage : vst_pkg

// file: vst_access_policy.sv
// Access policy per agent and register.
// Assumes the port fields come straight from the control register.
`timescale 1ns/1ps
module vst_access_policy
    import vst_pkg::*;
(
    input wire logic [1:0] src_in,
    input wire logic [4:0] port_in,
    input wire logic [11:0] addr_in,
    input wire logic [4:0] active_port_in,
    input wire logic active_en_in,
    input wire logic [4:0] redundant_port_in,
    input wire logic redundant_en_in,
    input wire logic hier_ok_in,
    output logic is_pci_out,
    output logic allow_out
);

    // ------------------------------------------------------------
    // Agent classification
    // ------------------------------------------------------------
    wire logic is_loader = (src_in == SRC_EEPROM) || (src_in == SRC_I2C);
    wire logic is_port = (src_in == SRC_PORT);
    // Bit 3 is never a port bit; it must be zero
    wire logic port_valid = ((port_in & ~PORT_FIELD_MASK) == 5'h00);
    wire logic is_active = is_port && port_valid && active_en_in && (port_in == active_port_in);
    wire logic is_redundant = is_port && port_valid && redundant_en_in && (port_in == redundant_port_in);
    wire logic pci_space = (addr_in < OFS_DEVICE_SPECIFIC_BASE);
    wire logic mpc_hit = (addr_in == OFS_MGMT_PORT_CONTROL);

    // ------------------------------------------------------------
    // Decision
    // ------------------------------------------------------------
    wire logic dev_allow = is_loader || is_active || (is_redundant && mpc_hit);
    wire logic pci_allow = is_loader || (is_port && hier_ok_in);

    assign is_pci_out = pci_space;
    assign allow_out = pci_space ? pci_allow : dev_allow;

endmodule : vst_access_policy

// file: vst_switch_table.sv
// Management port control and virtual switch table registers.
// Assumes straps are stable around reset release and requests are synchronous.
`timescale 1ns/1ps
module vst_switch_table
    import vst_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic MGMT_ENABLE_STRAP_N_IN,
    input wire logic [3:0] MGMT_PORT_SELECT_STRAPS_IN,
    input wire logic LINKUP_HOLD_STRAP_IN,
    input wire logic [1:0] SWITCH_COUNT_STRAPS_IN,
    input wire logic REG_REQ_IN,
    input wire logic REG_WRITE_IN,
    input wire logic [1:0] REG_SRC_IN,
    input wire logic [4:0] REG_PORT_IN,
    input wire logic [4:0] REG_TARGET_PORT_IN,
    input wire logic [11:0] REG_ADDR_IN,
    input wire logic [31:0] REG_WDATA_IN,
    input wire logic MGMT_LINK_EVENT_IN,
    output logic REG_ACK_OUT,
    output logic REG_REFUSED_OUT,
    output logic CFG_GRANT_OUT,
    output logic [31:0] REG_RDATA_OUT,
    output logic RELOAD_PORT_OUT,
    output logic RELOAD_CHIP_STATION_OUT,
    output logic [4:0] RELOAD_PORT_NUM_OUT,
    output logic [4:0] ACTIVE_MGMT_PORT_OUT,
    output logic ACTIVE_MGMT_EN_OUT,
    output logic [4:0] REDUNDANT_MGMT_PORT_OUT,
    output logic REDUNDANT_MGMT_EN_OUT,
    output logic [3:0] SWITCH_ENABLE_OUT,
    output logic LINK_HOLD_OUT
);

    // ------------------------------------------------------------
    // State
    // ------------------------------------------------------------
    vst_boot_t boot_r;
    vst_boot_t boot_nxt;
    logic [31:0] mpc_r;
    logic [31:0] enable_r;
    logic [31:0] upstream_r [NUM_SWITCHES];
    logic [31:0] vector_r [NUM_SWITCHES];
    logic release_r;
    logic hold_mode_r;
    logic ack_r;
    logic refused_r;
    logic grant_r;
    logic [31:0] rdata_r;
    logic [31:0] rdata_nxt;
    logic reload_port_r;
    logic reload_chip_r;
    logic [4:0] reload_num_r;

    // ------------------------------------------------------------
    // Strap decode
    // ------------------------------------------------------------
    // Top strap picks the station, lower three the port in it
    wire logic [4:0] strap_port = {MGMT_PORT_SELECT_STRAPS_IN[3], 1'b0, MGMT_PORT_SELECT_STRAPS_IN[2:0]};
    wire logic strap_mgmt_en = ~MGMT_ENABLE_STRAP_N_IN;
    wire logic strap_hold = ~MGMT_ENABLE_STRAP_N_IN & ~LINKUP_HOLD_STRAP_IN;
    wire logic strap_single = (SWITCH_COUNT_STRAPS_IN == COUNT_ONE);
    wire logic [3:0] strap_enables =
        (SWITCH_COUNT_STRAPS_IN == COUNT_BASE) ? ENABLE_ONE :
        (SWITCH_COUNT_STRAPS_IN == COUNT_ONE) ? ENABLE_ONE :
        (SWITCH_COUNT_STRAPS_IN == COUNT_TWO) ? ENABLE_TWO : ENABLE_FOUR;
    wire logic [31:0] strap_mpc = {26'h0, strap_mgmt_en, strap_port};
    wire logic [31:0] strap_vs0_vector = (strap_mgmt_en && strap_single) ? VECTOR_ALL_PORTS : VECTOR_RESET;
    wire logic take_straps = (boot_r == VST_STRAP_TAKE);

    // ------------------------------------------------------------
    // Boot sequencer
    // ------------------------------------------------------------
    // Straps load on the second edge after release, so no
    // flip-flop loads a port value in reset.
    always_comb begin
        case (boot_r)
            VST_STRAP_WAIT: boot_nxt = VST_STRAP_TAKE;
            VST_STRAP_TAKE: boot_nxt = VST_RUN;
            VST_RUN: boot_nxt = VST_RUN;
            default: boot_nxt = VST_STRAP_WAIT;
        endcase
    end

    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            boot_r <= VST_STRAP_WAIT;
        end else begin
            boot_r <= boot_nxt;
        end
    end

    // ------------------------------------------------------------
    // Field views of the control register
    // ------------------------------------------------------------
    wire logic [4:0] active_port = mpc_r[MPC_ACTIVE_LSB +: 5] & PORT_FIELD_MASK;
    wire logic active_en = mpc_r[MPC_ACTIVE_EN_BIT];
    wire logic reload_scope = mpc_r[MPC_RELOAD_SCOPE_BIT];
    wire logic [4:0] redundant_port = mpc_r[MPC_REDUNDANT_LSB +: 5] & PORT_FIELD_MASK;
    wire logic redundant_en = mpc_r[MPC_REDUNDANT_EN_BIT];

    // ------------------------------------------------------------
    // Hierarchy check for PCI-defined accesses
    // ------------------------------------------------------------
    logic [NUM_SWITCHES-1:0] hier_hit;
    logic [NUM_SWITCHES-1:0] up_sel;
    logic [NUM_SWITCHES-1:0] vec_sel;

    generate
        for (genvar s = 0; s < NUM_SWITCHES; s++) begin : g_hier
            wire logic [4:0] up_port = upstream_r[s][4:0] & PORT_FIELD_MASK;
            wire logic [31:0] member = vector_r[s] >> REG_TARGET_PORT_IN;
            assign hier_hit[s] = enable_r[s] && (REG_PORT_IN == up_port) && member[0];
            assign up_sel[s] = (REG_ADDR_IN == OFS_SWITCH_UPSTREAM_SELECT + OFS_TABLE_STRIDE * 12'(s));
            assign vec_sel[s] = (REG_ADDR_IN == OFS_SWITCH_PORT_MEMBERSHIP + OFS_TABLE_STRIDE * 12'(s));
        end
    endgenerate

    wire logic hier_ok = |hier_hit;

    // ------------------------------------------------------------
    // Access decision and address decode
    // ------------------------------------------------------------
    logic is_pci;
    logic allow;

    vst_access_policy u_policy (
        .src_in(REG_SRC_IN),
        .port_in(REG_PORT_IN),
        .addr_in(REG_ADDR_IN),
        .active_port_in(active_port),
        .active_en_in(active_en),
        .redundant_port_in(redundant_port),
        .redundant_en_in(redundant_en),
        .hier_ok_in(hier_ok),
        .is_pci_out(is_pci),
        .allow_out(allow)
    );

    // Requests during strap capture are dropped so the straps win
    wire logic live = REG_REQ_IN && (boot_r == VST_RUN);
    wire logic granted = live && allow;
    wire logic do_write = granted && REG_WRITE_IN && !is_pci;
    wire logic sel_mpc = (REG_ADDR_IN == OFS_MGMT_PORT_CONTROL);
    wire logic sel_enable = (REG_ADDR_IN == OFS_SWITCH_ENABLE_BITS);
    wire logic sel_release = (REG_ADDR_IN == OFS_CONFIGURATION_RELEASE);
    wire logic wr_mpc = do_write && sel_mpc;
    wire logic wr_enable = do_write && sel_enable;
    wire logic wr_release = do_write && sel_release && REG_WDATA_IN[RELEASE_BIT];

    // ------------------------------------------------------------
    // Management port control
    // ------------------------------------------------------------
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            mpc_r <= MPC_RESET;
        end else if (take_straps) begin
            mpc_r <= strap_mpc;
        end else if (wr_mpc) begin
            // Failover is a plain rewrite; new selection acts next cycle
            mpc_r <= REG_WDATA_IN & MPC_WMASK;
        end
    end

    // ------------------------------------------------------------
    // Switch enables
    // ------------------------------------------------------------
    // One write may retire one switch and raise another
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            enable_r <= ENABLE_RESET;
        end else if (take_straps) begin
            enable_r <= {28'h0, strap_enables};
        end else if (wr_enable) begin
            enable_r <= REG_WDATA_IN & ENABLE_WMASK;
        end
    end

    // ------------------------------------------------------------
    // Upstream and membership entries
    // ------------------------------------------------------------
    generate
        for (genvar s = 0; s < NUM_SWITCHES; s++) begin : g_entry
            wire logic wr_up = do_write && up_sel[s];
            wire logic wr_vec = do_write && vec_sel[s];
            wire logic [31:0] up_strap = (s == 0) ? {27'h0, strap_port} : UPSTREAM_RESET;
            wire logic [31:0] vec_strap = (s == 0) ? strap_vs0_vector : VECTOR_RESET;

            always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
                if (!RESET_N_IN) begin
                    upstream_r[s] <= UPSTREAM_RESET;
                end else if (take_straps) begin
                    upstream_r[s] <= up_strap;
                end else if (wr_up) begin
                    upstream_r[s] <= REG_WDATA_IN & UPSTREAM_WMASK;
                end
            end

            always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
                if (!RESET_N_IN) begin
                    vector_r[s] <= VECTOR_RESET;
                end else if (take_straps) begin
                    vector_r[s] <= vec_strap;
                end else if (wr_vec) begin
                    vector_r[s] <= REG_WDATA_IN & VECTOR_WMASK;
                end
            end
        end
    endgenerate

    // ------------------------------------------------------------
    // Link hold and configuration release
    // ------------------------------------------------------------
    // Hold is assumed until straps are known, so no port trains early
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            hold_mode_r <= 1'b1;
        end else if (take_straps) begin
            hold_mode_r <= strap_hold;
        end
    end

    // Only a one is meaningful; the bit stays set until reset
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            release_r <= 1'b0;
        end else if (wr_release) begin
            release_r <= 1'b1;
        end
    end

    assign LINK_HOLD_OUT = hold_mode_r && !release_r;

    // ------------------------------------------------------------
    // Read path
    // ------------------------------------------------------------
    logic [31:0] up_rd;
    logic [31:0] vec_rd;

    always_comb begin
        up_rd = 32'h0000_0000;
        vec_rd = 32'h0000_0000;
        for (int s = 0; s < NUM_SWITCHES; s++) begin
            if (up_sel[s]) begin
                up_rd = upstream_r[s];
            end
            if (vec_sel[s]) begin
                vec_rd = vector_r[s];
            end
        end
    end

    always_comb begin
        rdata_nxt = 32'h0000_0000;
        if (granted && !REG_WRITE_IN && !is_pci) begin
            if (sel_mpc) begin
                rdata_nxt = mpc_r & MPC_WMASK;
            end else if (sel_enable) begin
                rdata_nxt = enable_r & ENABLE_WMASK;
            end else if (sel_release) begin
                rdata_nxt = {31'h0, release_r} & RELEASE_WMASK;
            end else begin
                rdata_nxt = up_rd | vec_rd;
            end
        end
    end

    // ------------------------------------------------------------
    // Answer
    // ------------------------------------------------------------
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            ack_r <= 1'b0;
            refused_r <= 1'b0;
            grant_r <= 1'b0;
            rdata_r <= 32'h0000_0000;
        end else begin
            ack_r <= live;
            refused_r <= live && !allow;
            grant_r <= granted && is_pci;
            rdata_r <= rdata_nxt;
        end
    end

    // ------------------------------------------------------------
    // EEPROM reload request on management port hot reset
    // ------------------------------------------------------------
    // Scope is taken at the event; a later change
    // cannot widen a requested reload.
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) begin
            reload_port_r <= 1'b0;
            reload_chip_r <= 1'b0;
            reload_num_r <= 5'h00;
        end else begin
            reload_port_r <= MGMT_LINK_EVENT_IN && active_en;
            reload_chip_r <= MGMT_LINK_EVENT_IN && active_en && reload_scope;
            if (MGMT_LINK_EVENT_IN && active_en) begin
                reload_num_r <= active_port;
            end
        end
    end

    // ------------------------------------------------------------
    // Outputs
    // ------------------------------------------------------------
    assign REG_ACK_OUT = ack_r;
    assign REG_REFUSED_OUT = refused_r;
    assign CFG_GRANT_OUT = grant_r;
    assign REG_RDATA_OUT = rdata_r;
    assign RELOAD_PORT_OUT = reload_port_r;
    assign RELOAD_CHIP_STATION_OUT = reload_chip_r;
    assign RELOAD_PORT_NUM_OUT = reload_num_r;
    assign ACTIVE_MGMT_PORT_OUT = active_port;
    assign ACTIVE_MGMT_EN_OUT = active_en;
    assign REDUNDANT_MGMT_PORT_OUT = redundant_port;
    assign REDUNDANT_MGMT_EN_OUT = redundant_en;
    assign SWITCH_ENABLE_OUT = enable_r[3:0];

endmodule : vst_switch_table

// file: vst_switch_table_props.sv
// Concurrent checks on the switch table.
// Assumes a bind onto vst_switch_table, one clock, async reset.
`timescale 1ns/1ps
module vst_switch_table_props
    import vst_pkg::*;
(
    input wire logic CLK_IN,
    input wire logic RESET_N_IN,
    input wire logic REG_REQ_IN,
    input wire logic REG_WRITE_IN,
    input wire logic [1:0] REG_SRC_IN,
    input wire logic [4:0] REG_PORT_IN,
    input wire logic [11:0] REG_ADDR_IN,
    input wire logic [31:0] REG_WDATA_IN,
    input wire logic MGMT_LINK_EVENT_IN,
    input wire logic REG_ACK_OUT,
    input wire logic REG_REFUSED_OUT,
    input wire logic CFG_GRANT_OUT,
    input wire logic [31:0] REG_RDATA_OUT,
    input wire logic RELOAD_PORT_OUT,
    input wire logic RELOAD_CHIP_STATION_OUT,
    input wire logic [4:0] RELOAD_PORT_NUM_OUT,
    input wire logic [4:0] ACTIVE_MGMT_PORT_OUT,
    input wire logic ACTIVE_MGMT_EN_OUT,
    input wire logic [4:0] REDUNDANT_MGMT_PORT_OUT,
    input wire logic [3:0] SWITCH_ENABLE_OUT,
    input wire logic LINK_HOLD_OUT
);
    // Boot edges drop requests
    logic [1:0] boot_cnt_r;
    logic [1:0] boot_cnt_nxt;
    logic taken;
    logic enable_wr;
    assign boot_cnt_nxt = (boot_cnt_r == 2'h3) ? boot_cnt_r : boot_cnt_r + 2'h1;
    assign taken = REG_REQ_IN && boot_cnt_r[1];
    assign enable_wr = taken && REG_WRITE_IN && (REG_ADDR_IN == OFS_SWITCH_ENABLE_BITS);
    always_ff @(posedge CLK_IN or negedge RESET_N_IN) begin
        if (!RESET_N_IN) boot_cnt_r <= 2'h0;
        else boot_cnt_r <= boot_cnt_nxt;
    end

    default clocking @(posedge CLK_IN); endclocking
    default disable iff (!RESET_N_IN);

    sequence s_enable_write;
        enable_wr && (REG_SRC_IN == SRC_EEPROM);
    endsequence
    sequence s_release_write;
        taken && REG_WRITE_IN && (REG_ADDR_IN == OFS_CONFIGURATION_RELEASE) && REG_WDATA_IN[0] && (REG_SRC_IN == SRC_I2C);
    endsequence

    ack_on_take_a: assert property (taken |=> REG_ACK_OUT)
        else $error("ack missing");
    ack_needs_req_a: assert property (!taken |=> !REG_ACK_OUT)
        else $error("stray ack");
    refused_zero_a: assert property (REG_REFUSED_OUT |-> REG_ACK_OUT && REG_RDATA_OUT == 32'h0)
        else $error("bad refusal");
    bit3_refused_a: assert property (taken && REG_SRC_IN == SRC_PORT && REG_PORT_IN[3] |=> REG_REFUSED_OUT)
        else $error("bit 3 port let in");
    agent_allowed_a: assert property (taken && (REG_SRC_IN == SRC_EEPROM || REG_SRC_IN == SRC_I2C) |=> !REG_REFUSED_OUT)
        else $error("loader refused");
    enable_apply_a: assert property (s_enable_write |=> SWITCH_ENABLE_OUT == $past(REG_WDATA_IN[3:0]))
        else $error("enables not written");
    enable_cause_a: assert property (boot_cnt_r == 2'h3 && $changed(SWITCH_ENABLE_OUT) |-> $past(enable_wr))
        else $error("stray enable change");
    release_drop_a: assert property (s_release_write |=> !LINK_HOLD_OUT)
        else $error("hold not released");
    hold_no_rise_a: assert property (boot_cnt_r == 2'h3 |-> !$rose(LINK_HOLD_OUT))
        else $error("hold rose");
    reload_pulse_a: assert property (MGMT_LINK_EVENT_IN && ACTIVE_MGMT_EN_OUT
        |=> RELOAD_PORT_OUT && RELOAD_PORT_NUM_OUT == $past(ACTIVE_MGMT_PORT_OUT))
        else $error("reload wrong");
    reload_cause_a: assert property (!(MGMT_LINK_EVENT_IN && ACTIVE_MGMT_EN_OUT)
        |=> !RELOAD_PORT_OUT && !RELOAD_CHIP_STATION_OUT)
        else $error("stray reload");
    port_bit3_zero_a: assert property (ACTIVE_MGMT_PORT_OUT[3] == 1'b0 && REDUNDANT_MGMT_PORT_OUT[3] == 1'b0)
        else $error("port bit 3 set");
    grant_with_ack_a: assert property (CFG_GRANT_OUT |-> REG_ACK_OUT && !REG_REFUSED_OUT)
        else $error("stray grant");
endmodule : vst_switch_table_props

bind vst_switch_table vst_switch_table_props i_vst_switch_table_props (.*);

// file: vst_agent_model.sv
// Register agent model issuing single-word accesses.
// Assumes the bench calls its tasks.
`timescale 1ns/1ps
module vst_agent_model (
    input wire logic clk_in,
    output logic req_out,
    output logic wr_out,
    output logic [1:0] src_out,
    output logic [4:0] port_out,
    output logic [4:0] tgt_out,
    output logic [11:0] addr_out,
    output logic [31:0] wdata_out
);
    initial begin
        {req_out, wr_out, src_out, port_out, tgt_out, addr_out, wdata_out} = '0;
    end
    // Whole word per access: no half-written entry
    task automatic access(input logic [1:0] src, input logic [4:0] port, input logic [4:0] tgt,
                          input logic [11:0] addr, input logic wr, input logic [31:0] wdata);
        @(posedge clk_in);
        #1;
        req_out = 1'b1;
        {wr_out, src_out, port_out, tgt_out, addr_out, wdata_out} = {wr, src, port, tgt, addr, wdata};
    endtask : access
    // Address and data lines flip on release to expose stale use
    task automatic idle();
        @(posedge clk_in);
        #1;
        req_out = 1'b0;
        addr_out = ~addr_out;
        wdata_out = ~wdata_out;
    endtask : idle
endmodule : vst_agent_model

// file: vst_switch_table_tb.sv
// Self-checking bench for vst_switch_table.
// Assumes straps fixed from time zero: management enabled, port 13h, one switch, link hold.
`timescale 1ns/1ps
module vst_switch_table_tb
    import vst_pkg::*;
;
    logic clk, rst_n, evt, ack, refused, grant, rl_port, rl_chip, act_en, red_en, hold;
    logic req, wr;
    logic [1:0] src;
    logic [4:0] port, tgt, rl_num, act_port, red_port;
    logic [11:0] addr;
    logic [31:0] wdata, rdata, w;
    logic [3:0] sw_en;
    logic [32:0] exp_q[$];
    logic [32:0] exp_v;
    int bad_count = 0;
    int comparisons = 0;
    integer seed = 32'h4d26ed37;
    logic [11:0] ra [8] = '{12'h354, 12'h358, 12'h360, 12'h364, 12'h380, 12'h384, 12'h3ac, 12'h3f0};
    logic [31:0] rv [8] = '{32'h33, 32'h1, 32'h13, 32'h0, 32'h00ff_000f, 32'h0, 32'h0, 32'h0};

    vst_agent_model i_vst_agent_model (.clk_in(clk), .req_out(req), .wr_out(wr), .src_out(src), .port_out(port),
        .tgt_out(tgt), .addr_out(addr), .wdata_out(wdata));
    vst_switch_table i_vst_switch_table (.CLK_IN(clk), .RESET_N_IN(rst_n), .MGMT_ENABLE_STRAP_N_IN(1'b0),
        .MGMT_PORT_SELECT_STRAPS_IN(4'hb), .LINKUP_HOLD_STRAP_IN(1'b0), .SWITCH_COUNT_STRAPS_IN(2'h1),
        .REG_REQ_IN(req), .REG_WRITE_IN(wr), .REG_SRC_IN(src), .REG_PORT_IN(port), .REG_TARGET_PORT_IN(tgt),
        .REG_ADDR_IN(addr), .REG_WDATA_IN(wdata), .MGMT_LINK_EVENT_IN(evt), .REG_ACK_OUT(ack),
        .REG_REFUSED_OUT(refused), .CFG_GRANT_OUT(grant), .REG_RDATA_OUT(rdata), .RELOAD_PORT_OUT(rl_port),
        .RELOAD_CHIP_STATION_OUT(rl_chip), .RELOAD_PORT_NUM_OUT(rl_num), .ACTIVE_MGMT_PORT_OUT(act_port),
        .ACTIVE_MGMT_EN_OUT(act_en), .REDUNDANT_MGMT_PORT_OUT(red_port), .REDUNDANT_MGMT_EN_OUT(red_en),
        .SWITCH_ENABLE_OUT(sw_en), .LINK_HOLD_OUT(hold));

    initial begin
        clk = 1'b0;
        forever #12.5 clk = ~clk;
    end

    task automatic chk(input logic [32:0] got, input logic [32:0] exp);
        comparisons++;
        if (got !== exp) begin
            bad_count++;
            $display("mismatch at %0t: got %h expected %h", $time, got, exp);
        end
    endtask : chk
    task automatic acc(input logic [1:0] s, input logic [4:0] p, input logic [11:0] a, input logic wrt,
                       input logic [31:0] d, input logic [32:0] exp);
        exp_q.push_back(exp);
        i_vst_agent_model.access(s, p, 5'h0, a, wrt, d);
    endtask : acc
    task automatic pulse(input logic [32:0] exp);
        i_vst_agent_model.idle();
        evt = 1'b1;
        @(posedge clk);
        #1;
        evt = 1'b0;
        chk({26'h0, rl_port, rl_chip, rl_num}, exp);
    endtask : pulse
    task automatic print_verdict();
        $display("comparisons %0d bad_count %0d", comparisons, bad_count);
        if (bad_count == 0 && comparisons > 0) $display("verification passed");
        else $display("verification failed");
        $finish;
    endtask : print_verdict

    // ------------------------------------------------------------
    // Result monitor
    // ------------------------------------------------------------
    always @(negedge clk) begin
        if (ack === 1'b1) begin
            exp_v = exp_q.size() > 0 ? exp_q.pop_front() : 33'h1_dead_beef;
            chk({refused, rdata}, exp_v);
        end
    end

    initial begin
        #(25 * 4000);
        bad_count++;
        print_verdict();
    end

    initial begin
        rst_n = 1'b0;
        evt = 1'b0;
        repeat (16) @(posedge clk);
        #1;
        rst_n = 1'b1;
        repeat (2) @(posedge clk);
        for (int i = 0; i < 8; i++) acc(SRC_EEPROM, 5'h0, ra[i], 1'b0, 32'h0, {1'b0, rv[i]});
        chk({26'h0, hold, act_en, act_port}, {26'h0, 1'b1, 1'b1, 5'h13});
        acc(SRC_I2C, 5'h0, OFS_MGMT_PORT_CONTROL, 1'b1, 32'hffff_ffff, 33'h0);
        acc(SRC_I2C, 5'h0, OFS_MGMT_PORT_CONTROL, 1'b0, 32'h0, {1'b0, 32'h3777});
        acc(SRC_EEPROM, 5'h0, OFS_MGMT_PORT_CONTROL, 1'b1, 32'h2133, 33'h0);
        acc(SRC_PORT, 5'h13, OFS_SWITCH_ENABLE_BITS, 1'b1, 32'h5, 33'h0);
        acc(SRC_PORT, 5'h01, OFS_SWITCH_ENABLE_BITS, 1'b0, 32'h0, {1'b1, 32'h0});
        acc(SRC_PORT, 5'h01, OFS_MGMT_PORT_CONTROL, 1'b0, 32'h0, {1'b0, 32'h2133});
        acc(SRC_PORT, 5'h02, OFS_SWITCH_ENABLE_BITS, 1'b1, 32'ha, {1'b1, 32'h0});
        acc(SRC_PORT, 5'h1b, OFS_SWITCH_ENABLE_BITS, 1'b0, 32'h0, {1'b1, 32'h0});
        acc(2'h3, 5'h13, OFS_SWITCH_ENABLE_BITS, 1'b0, 32'h0, {1'b1, 32'h0});
        acc(SRC_PORT, 5'h13, 12'h010, 1'b0, 32'h0, 33'h0);
        acc(SRC_PORT, 5'h02, 12'h010, 1'b0, 32'h0, {1'b1, 32'h0});
        acc(SRC_PORT, 5'h13, OFS_SWITCH_ENABLE_BITS, 1'b0, 32'h0, {1'b0, 32'h5});
        // Table entries first, enables last
        for (int k = 0; k < 4; k++) begin
            w = $random(seed);
            acc(SRC_EEPROM, 5'h0, 12'h360 + 12'(4 * k), 1'b1, w, 33'h0);
            acc(SRC_I2C, 5'h0, 12'h360 + 12'(4 * k), 1'b0, 32'h0, {1'b0, w & UPSTREAM_WMASK});
            w = $random(seed);
            acc(SRC_EEPROM, 5'h0, 12'h380 + 12'(4 * k), 1'b1, w, 33'h0);
            acc(SRC_I2C, 5'h0, 12'h380 + 12'(4 * k), 1'b0, 32'h0, {1'b0, w & VECTOR_WMASK});
        end
        w = $random(seed);
        acc(SRC_EEPROM, 5'h0, OFS_SWITCH_ENABLE_BITS, 1'b1, w, 33'h0);
        i_vst_agent_model.idle();
        chk({29'h0, sw_en}, {29'h0, w[3:0]});
        acc(SRC_EEPROM, 5'h0, OFS_MGMT_PORT_CONTROL, 1'b1, 32'h2173, 33'h0);
        pulse({26'h0, 1'b1, 1'b1, 5'h13});
        acc(SRC_EEPROM, 5'h0, OFS_MGMT_PORT_CONTROL, 1'b1, 32'h2133, 33'h0);
        pulse({26'h0, 1'b1, 1'b0, 5'h13});
        acc(SRC_I2C, 5'h0, OFS_CONFIGURATION_RELEASE, 1'b1, 32'h0, 33'h0);
        i_vst_agent_model.idle();
        chk({32'h0, hold}, 33'h1);
        acc(SRC_I2C, 5'h0, OFS_CONFIGURATION_RELEASE, 1'b1, 32'h1, 33'h0);
        i_vst_agent_model.idle();
        chk({32'h0, hold}, 33'h0);
        acc(SRC_PORT, 5'h01, OFS_MGMT_PORT_CONTROL, 1'b1, 32'h3321, 33'h0);
        acc(SRC_PORT, 5'h01, OFS_SWITCH_ENABLE_BITS, 1'b0, 32'h0, {1'b0, 28'h0, w[3:0]});
        acc(SRC_PORT, 5'h13, OFS_SWITCH_ENABLE_BITS, 1'b0, 32'h0, {1'b1, 32'h0});
        i_vst_agent_model.idle();
        chk({26'h0, red_en, act_en, act_port}, {26'h0, 1'b1, 1'b1, 5'h01});
        repeat (2) @(posedge clk);
        chk(33'(exp_q.size()), 33'h0);
        print_verdict();
    end
endmodule : vst_switch_table_tb
